// file: rtl/frsc_cfg.svh
// Opcodes, header byte values and timing constants for the command slice
`ifndef FRSC_CFG_SVH
`define FRSC_CFG_SVH

`define FRSC_OP_RESUME 8'h30
`define FRSC_OP_NOP 8'h00
`define FRSC_OP_RST_ARM 8'h66
`define FRSC_OP_RST 8'h99
`define FRSC_OP_PTAB 8'h5A

`define FRSC_SI 0
`define FRSC_SO 1

`define FRSC_HDR_SIG0 8'h53
`define FRSC_HDR_SIG1 8'h46
`define FRSC_HDR_SIG2 8'h44
`define FRSC_HDR_SIG3 8'h50
`define FRSC_HDR_MINOR 8'h06
`define FRSC_HDR_MAJOR 8'h01
`define FRSC_HDR_NPH 8'h02
`define FRSC_HDR_FILL 8'hFF
`define FRSC_HDR_ZERO 8'h00
`define FRSC_PH0_ID 8'h00
`define FRSC_PH0_MINOR 8'h06
`define FRSC_PH0_MAJOR 8'h01
`define FRSC_PH0_LEN 8'h10
`define FRSC_PH0_PTR 8'h30
`define FRSC_PH1_MINOR 8'h00
`define FRSC_PH1_MAJOR 8'h01
`define FRSC_PH1_LEN 8'h04
`define FRSC_PH1_PTR0 8'h10
`define FRSC_PH1_PTR1 8'h01
`define FRSC_PH2_ID 8'h84
`define FRSC_PH2_MINOR 8'h00
`define FRSC_PH2_MAJOR 8'h01
`define FRSC_PH2_LEN 8'h02
`define FRSC_PH2_PTR 8'hC0

`define FRSC_CLK_MHZ 25
`define FRSC_RECOV_IDLE_NS 40000
`define FRSC_RECOV_WRITE_NS 12000000
`define FRSC_RECOV_IDLE_CYC ((`FRSC_RECOV_IDLE_NS * `FRSC_CLK_MHZ + 999) / 1000)
`define FRSC_RECOV_WRITE_CYC ((`FRSC_RECOV_WRITE_NS * `FRSC_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/frsc_pkg.sv
// Types shared by the command slice: link state and the module state record
package frsc_pkg;
    typedef enum logic [2:0] {
        ST_CMD = 3'h0,
        ST_ADDR = 3'h1,
        ST_DUMMY = 3'h3,
        ST_DATA = 3'h2,
        ST_SKIP = 3'h6
    } frsc_state_e;

    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic ck1;
        logic ck2;
        logic ck3;
        logic [3:0] d1;
        logic [3:0] d2;
        frsc_state_e st;
        logic [4:0] bitc;
        logic [7:0] shin;
        logic [7:0] opc;
        logic have_op;
        logic exact;
        logic [23:0] addr;
        logic [2:0] obit;
        logic [7:0] osh;
        logic arm;
        logic esf;
        logic psf;
        logic [31:0] recov;
        logic ready;
        logic busy;
        logic resume;
        logic abort;
        logic swrst;
        logic [3:0] sio;
        logic [3:0] sio_oe;
    } frsc_regs_s;
endpackage : frsc_pkg

// file: rtl/frsc_top.sv
// Serial flash command slice: write resume, no-op, soft reset, parameter header read
`timescale 1ns/100ps
`include "frsc_cfg.svh"

module frsc_top
    import frsc_pkg::*;
#(
    parameter int unsigned RECOV_IDLE_CYC = `FRSC_RECOV_IDLE_CYC,
    parameter int unsigned RECOV_WRITE_CYC = `FRSC_RECOV_WRITE_CYC,
    // Value is arbitrary
    parameter logic [7:0] MAKER_ID = 8'h5C
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] sio_i,
    input wire logic quad_mode_i,
    input wire logic perf_enhance_i,
    input wire logic erase_suspend_req_i,
    input wire logic program_suspend_req_i,
    input wire logic write_active_i,
    output logic [3:0] sio_o,
    output logic [3:0] sio_oe_o,
    output logic erase_suspended_flag_o,
    output logic program_suspended_flag_o,
    output logic busy_o,
    output logic ready_o,
    output logic resume_o,
    output logic write_abort_o,
    output logic soft_reset_o
);

    frsc_regs_s r;
    frsc_regs_s n;

    logic live;
    logic rise;
    logic fall;
    logic cs_rise;
    logic quad;
    logic bdone;
    logic cmd_end;
    logic do_resume;
    logic do_reset;
    logic [4:0] step;
    logic [4:0] lim;
    logic [4:0] bsum;
    logic [7:0] sin_b;

    // Header area lookup; addresses past the headers read as fill
    function automatic logic [7:0] frsc_hdr_byte(input logic [23:0] a);
        logic [7:0] v;
        v = `FRSC_HDR_FILL;
        if (a[23:5] == 19'h0) begin
            case (a[4:0])
                5'h00: v = `FRSC_HDR_SIG0;
                5'h01: v = `FRSC_HDR_SIG1;
                5'h02: v = `FRSC_HDR_SIG2;
                5'h03: v = `FRSC_HDR_SIG3;
                5'h04: v = `FRSC_HDR_MINOR;
                5'h05: v = `FRSC_HDR_MAJOR;
                5'h06: v = `FRSC_HDR_NPH;
                5'h08: v = `FRSC_PH0_ID;
                5'h09: v = `FRSC_PH0_MINOR;
                5'h0A: v = `FRSC_PH0_MAJOR;
                5'h0B: v = `FRSC_PH0_LEN;
                5'h0C: v = `FRSC_PH0_PTR;
                5'h0D: v = `FRSC_HDR_ZERO;
                5'h0E: v = `FRSC_HDR_ZERO;
                5'h10: v = MAKER_ID;
                5'h11: v = `FRSC_PH1_MINOR;
                5'h12: v = `FRSC_PH1_MAJOR;
                5'h13: v = `FRSC_PH1_LEN;
                5'h14: v = `FRSC_PH1_PTR0;
                5'h15: v = `FRSC_PH1_PTR1;
                5'h16: v = `FRSC_HDR_ZERO;
                5'h18: v = `FRSC_PH2_ID;
                5'h19: v = `FRSC_PH2_MINOR;
                5'h1A: v = `FRSC_PH2_MAJOR;
                5'h1B: v = `FRSC_PH2_LEN;
                5'h1C: v = `FRSC_PH2_PTR;
                5'h1D: v = `FRSC_HDR_ZERO;
                5'h1E: v = `FRSC_HDR_ZERO;
                default: v = `FRSC_HDR_FILL;
            endcase
        end
        return v;
    endfunction : frsc_hdr_byte

    // Link edges come from the second and third sync stages only
    assign live = ~r.cs2 & r.ready;
    assign rise = live & r.ck2 & ~r.ck3;
    assign fall = live & ~r.ck2 & r.ck3;
    assign cs_rise = r.cs2 & ~r.cs3;
    assign quad = quad_mode_i;

    // Single line takes SI only, quad takes all four lines per clock
    assign step = quad ? 5'h4 : 5'h1;
    assign lim = (r.st == ST_ADDR) ? 5'h18 : 5'h08;
    assign bsum = r.bitc + step;
    assign bdone = (bsum == lim);
    assign sin_b = quad ? {r.shin[3:0], r.d2} : {r.shin[6:0], r.d2[`FRSC_SI]};

    // Commands act only when chip select rises right after the opcode byte, with no extra clock
    assign cmd_end = cs_rise & r.have_op & r.exact & r.ready;
    assign do_resume = cmd_end & (r.opc == `FRSC_OP_RESUME) & ~perf_enhance_i
                       & (r.esf | r.psf);
    assign do_reset = cmd_end & (r.opc == `FRSC_OP_RST) & r.arm;

    // Next-state logic for the whole slice
    always_comb begin
        logic [7:0] ob;
        ob = 8'h00;
        n = r;
        n.cs1 = cs_n_i;
        n.cs2 = r.cs1;
        n.cs3 = r.cs2;
        n.ck1 = sclk_i;
        n.ck2 = r.ck1;
        n.ck3 = r.ck2;
        n.d1 = sio_i;
        n.d2 = r.d1;
        n.resume = 1'b0;
        n.abort = 1'b0;
        n.swrst = 1'b0;

        // Frame handling; during recovery any frame is dropped and held in ST_SKIP with outputs released
        if (r.cs2 | ~r.ready) begin
            n.st = r.cs2 ? ST_CMD : ST_SKIP;
            n.bitc = 5'h00;
            n.obit = 3'h0;
            n.sio_oe = 4'h0;
            if (cs_rise) begin
                // Any other framed command drops a pending arm
                if (r.have_op) begin
                    n.arm = (r.opc == `FRSC_OP_RST_ARM) & r.exact;
                end
                n.have_op = 1'b0;
            end
        end else begin
            if (rise) begin
                case (r.st)
                    ST_CMD: begin
                        n.shin = sin_b;
                        n.bitc = bdone ? 5'h00 : bsum;
                        if (bdone) begin
                            n.opc = sin_b;
                            n.have_op = 1'b1;
                            n.exact = 1'b1;
                            n.st = (sin_b == `FRSC_OP_PTAB) ? ST_ADDR : ST_SKIP;
                        end
                    end
                    ST_ADDR: begin
                        n.addr = quad ? {r.addr[19:0], r.d2} : {r.addr[22:0], r.d2[`FRSC_SI]};
                        n.bitc = bdone ? 5'h00 : bsum;
                        if (bdone) begin
                            n.st = ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        n.bitc = bdone ? 5'h00 : bsum;
                        if (bdone) begin
                            n.st = ST_DATA;
                            n.obit = 3'h0;
                        end
                    end
                    ST_DATA: begin
                        n.st = ST_DATA;
                    end
                    ST_SKIP: begin
                        // Extra clocks past the opcode make it a broken frame
                        n.exact = 1'b0;
                    end
                    default: begin
                        n.st = ST_SKIP;
                    end
                endcase
            end
            // Drive on the falling edge so the host samples on the next rise
            if (fall && (r.st == ST_DATA)) begin
                if (r.obit == 3'h0) begin
                    ob = frsc_hdr_byte(r.addr);
                    n.addr = r.addr + 24'h000001;
                end else begin
                    ob = r.osh;
                end
                n.osh = quad ? {ob[3:0], 4'h0} : {ob[6:0], 1'b0};
                n.obit = quad ? 3'(r.obit + 3'h4) : 3'(r.obit + 3'h1);
                n.sio = quad ? ob[7:4] : {2'b00, ob[7], 1'b0};
                n.sio_oe = quad ? 4'hF : 4'h2;
            end
        end

        // Suspend flags: a new suspend wins over a resume or reset clear
        n.esf = erase_suspend_req_i | (r.esf & ~do_resume & ~do_reset);
        n.psf = program_suspend_req_i | (r.psf & ~do_resume & ~do_reset);
        n.resume = do_resume;

        // Soft reset: recovery length depends on what was running
        if (do_reset) begin
            n.arm = 1'b0;
            n.swrst = 1'b1;
            n.abort = write_active_i;
            n.recov = write_active_i ? 32'(RECOV_WRITE_CYC) : 32'(RECOV_IDLE_CYC);
            n.sio_oe = 4'h0;
            n.st = ST_SKIP;
            n.have_op = 1'b0;
        end else if (r.recov != 32'h0) begin
            n.recov = r.recov - 32'h1;
        end
        n.ready = (n.recov == 32'h0);
        // Busy covers a running write that is not suspended, and recovery
        n.busy = (write_active_i & ~n.esf & ~n.psf & ~do_reset) | ~n.ready;
    end

    // State register; synchronous active-low reset to constants only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.cs1 <= 1'b1;
            r.cs2 <= 1'b1;
            r.cs3 <= 1'b1;
            r.ready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // All outputs straight from the state register
    assign sio_o = r.sio;
    assign sio_oe_o = r.sio_oe;
    assign erase_suspended_flag_o = r.esf;
    assign program_suspended_flag_o = r.psf;
    assign busy_o = r.busy;
    assign ready_o = r.ready;
    assign resume_o = r.resume;
    assign write_abort_o = r.abort;
    assign soft_reset_o = r.swrst;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_cmd_end(logic [7:0] op);
        cs_rise && r.have_op && r.exact && r.ready && (r.opc == op);
    endsequence

    sequence s_no_susp_req;
        !erase_suspend_req_i && !program_suspend_req_i;
    endsequence

    property p_resume_clears;
        s_cmd_end(`FRSC_OP_RESUME) ##0 (!perf_enhance_i && (r.esf || r.psf)) ##0 s_no_susp_req
            |=> resume_o && !erase_suspended_flag_o && !program_suspended_flag_o;
    endproperty
    a_resume_clears: assert property (p_resume_clears)
        else $error("resume did not clear the suspended flags");

    property p_resume_blocked;
        s_cmd_end(`FRSC_OP_RESUME) ##0 perf_enhance_i |=> !resume_o;
    endproperty
    a_resume_blocked: assert property (p_resume_blocked)
        else $error("resume taken during performance-enhance mode");

    property p_resume_busy;
        do_resume && write_active_i ##0 s_no_susp_req |=> busy_o && resume_o;
    endproperty
    a_resume_busy: assert property (p_resume_busy)
        else $error("busy not reported after resume");

    property p_nop_disarms;
        s_cmd_end(`FRSC_OP_NOP) |=> !r.arm ##1 !soft_reset_o;
    endproperty
    a_nop_disarms: assert property (p_nop_disarms)
        else $error("no-operation left the reset armed");

    property p_reset_needs_arm;
        s_cmd_end(`FRSC_OP_RST) ##0 !r.arm |=> !soft_reset_o && ready_o == $past(r.ready);
    endproperty
    a_reset_needs_arm: assert property (p_reset_needs_arm)
        else $error("reset executed without a preceding arm");

    property p_reset_defaults;
        soft_reset_o && !$past(erase_suspend_req_i) && !$past(program_suspend_req_i)
            |-> !erase_suspended_flag_o && !program_suspended_flag_o && !r.arm && busy_o;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("volatile state not cleared by soft reset");

    property p_reset_abort;
        s_cmd_end(`FRSC_OP_RST) ##0 (r.arm && write_active_i) |=> soft_reset_o && write_abort_o;
    endproperty
    a_reset_abort: assert property (p_reset_abort)
        else $error("write not aborted by soft reset");

    property p_recovery;
        soft_reset_o |-> !ready_o [*2];
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("device ready too soon after reset");

    property p_cs_stops_drive;
        cs_rise |=> (sio_oe_o == 4'h0) [*2];
    endproperty
    a_cs_stops_drive: assert property (p_cs_stops_drive)
        else $error("data still driven after chip select rose");

    property p_addr_step;
        fall && (r.st == ST_DATA) && (r.obit == 3'h0) && !do_reset
            |=> (r.addr == $past(r.addr) + 24'h000001) && (sio_oe_o != 4'h0);
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("table address did not step at a byte boundary");

    property p_erase_susp;
        erase_suspend_req_i |=> erase_suspended_flag_o;
    endproperty
    a_erase_susp: assert property (p_erase_susp)
        else $error("erase-suspended flag not set");

    property p_prog_susp;
        program_suspend_req_i |=> program_suspended_flag_o;
    endproperty
    a_prog_susp: assert property (p_prog_susp)
        else $error("program-suspended flag not set");

endmodule : frsc_top

// file: verif/frsc_host.sv
// Host flash controller model driving the serial command link
`timescale 1ns/100ps
module frsc_host (
    input wire logic clk_i,
    input wire logic quad_i,
    input wire logic [3:0] sio_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] sio_o
);
    logic [3:0] pat;
    logic [7:0] rd [64];
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sio_o = 4'h0;
        pat = 4'h5;
    end
    // Step n clock edges, then move just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // One serial clock: 5 cycles low, 3 high; the long low phase gives read margin
    task automatic beat(input logic [3:0] d, output logic [3:0] q);
        pat = ~pat;
        sio_o = d;
        tick(5);
        q = sio_i;
        sclk_o = 1'b1;
        tick(3);
        sclk_o = 1'b0;
    endtask : beat
    // One byte, MSB first; unused lines toggle so a leak into the command shows
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        logic [3:0] q;
        if (quad_i) begin
            beat(b[7:4], q);
            r[7:4] = q;
            beat(b[3:0], q);
            r[3:0] = q;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                beat({pat[3:1], b[i]}, q);
                r[i] = q[1];
            end
        end
    endtask : xfer
    task automatic start();
        tick(1);
        cs_n_o = 1'b0;
        tick(2);
    endtask : start
    // Idle gap after each frame keeps the required spacing
    task automatic stop();
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        tick(6);
    endtask : stop
    // Short command, optionally with one surplus serial clock
    task automatic cmd(input logic [7:0] op, input logic extra);
        logic [7:0] r;
        logic [3:0] q;
        start();
        xfer(op, r);
        if (extra) begin
            beat(pat, q);
        end
        stop();
    endtask : cmd
    // Table read: opcode, three address bytes, one dummy, then n data bytes
    task automatic ptab_read(input logic [23:0] a, input int n);
        logic [7:0] r;
        start();
        xfer(8'h5A, r);
        xfer(a[23:16], r);
        xfer(a[15:8], r);
        xfer(a[7:0], r);
        xfer(8'h00, r);
        for (int k = 0; k < n; k++) begin
            xfer(8'h00, r);
            rd[k] = r;
        end
        stop();
    endtask : ptab_read
endmodule : frsc_host

// file: verif/frsc_top_tb_top.sv
// Self-checking bench for the flash command slice
`timescale 1ns/100ps
module frsc_top_tb_top;
    localparam int unsigned RI = 40;
    localparam int unsigned RW = 200;
    localparam logic [7:0] MID = 8'hA7; // Value is arbitrary
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic quad, perf, esr, psr, wact;
    logic cs_n, sclk, esf, psf, busy, ready, res, abt, srst;
    logic [3:0] host_sio, dut_sio, sio_oe, sio_w;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_res = 0;
    int n_rst = 0;
    int n_abt = 0;
    logic [7:0] hdr [32] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hFF,
        8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF,
        MID, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00, 8'hFF,
        8'h84, 8'h00, 8'h01, 8'h02, 8'hC0, 8'h00, 8'h00, 8'hFF};
    // Each line carries whoever enables it
    assign sio_w = (sio_oe & dut_sio) | (~sio_oe & host_sio);
    always #20 clk_i = ~clk_i;
    // Pulses are only one cycle wide, so count them rather than sample
    always @(posedge clk_i) begin
        if (res === 1'b1) n_res++;
        if (srst === 1'b1) n_rst++;
        if (abt === 1'b1) n_abt++;
    end
    frsc_host u_host (.clk_i(clk_i), .quad_i(quad), .sio_i(sio_w), .cs_n_o(cs_n),
        .sclk_o(sclk), .sio_o(host_sio));
    frsc_top #(.RECOV_IDLE_CYC(RI), .RECOV_WRITE_CYC(RW), .MAKER_ID(MID)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(sio_w),
        .quad_mode_i(quad), .perf_enhance_i(perf), .erase_suspend_req_i(esr),
        .program_suspend_req_i(psr), .write_active_i(wact), .sio_o(dut_sio),
        .sio_oe_o(sio_oe), .erase_suspended_flag_o(esf), .program_suspended_flag_o(psf),
        .busy_o(busy), .ready_o(ready), .resume_o(res), .write_abort_o(abt),
        .soft_reset_o(srst));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    // Count cycles until ready; running out of the bound ends the run
    task automatic wait_ready(input int lim, output int n);
        n = 0;
        while (ready !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            test_done();
        end
    endtask : wait_ready
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        int r0, n;
        {quad, perf, esr, psr, wact} = 5'h00;
        cyc(3);
        resetn_i = 1'b1;
        cyc(3);
        check({ready, busy, esf, psf, sio_oe}, 8'h80);
        // Erase suspend in single mode, program suspend in quad mode
        for (int k = 0; k < 2; k++) begin
            wact = 1'b1;
            quad = (k == 1);
            esr = (k == 0);
            psr = (k == 1);
            cyc(1);
            {esr, psr} = 2'b00;
            cyc(1);
            check({esf, psf, busy}, (k == 0) ? 3'h4 : 3'h2);
            r0 = n_res;
            perf = 1'b1;
            u_host.cmd(8'h30, 1'b0);
            check({esf, psf, n_res[3:0]}, {(k == 0), (k == 1), r0[3:0]});
            perf = 1'b0;
            u_host.cmd(8'h30, 1'b1);
            check(n_res, r0);
            u_host.cmd(8'h30, 1'b0);
            check(n_res, r0 + 1);
            check({esf, psf, busy}, 3'h1);
            cyc(20);
        end
        quad = 1'b0;
        wact = 1'b0;
        r0 = n_rst;
        u_host.cmd(8'h66, 1'b0);
        u_host.cmd(8'h00, 1'b0);
        u_host.cmd(8'h99, 1'b0);
        check(n_rst, r0);
        u_host.cmd(8'h66, 1'b0);
        u_host.cmd(8'h99, 1'b1);
        check(n_rst, r0);
        psr = 1'b1;
        cyc(1);
        psr = 1'b0;
        u_host.cmd(8'h66, 1'b0);
        u_host.cmd(8'h99, 1'b0);
        check(n_rst, r0 + 1);
        check(n_abt, 32'h0);
        check({ready, busy, esf, psf}, 4'h4);
        wait_ready(RI + 10, n);
        check(n + 8 >= RI && n <= RI, 1'b1);
        // Reset during a write aborts it and takes the longer recovery
        wact = 1'b1;
        u_host.cmd(8'h66, 1'b0);
        u_host.cmd(8'h99, 1'b0);
        check(n_rst, r0 + 2);
        check(n_abt, 32'h1);
        check(ready, 1'b0);
        esr = 1'b1;
        cyc(1);
        esr = 1'b0;
        r0 = n_res;
        u_host.cmd(8'h30, 1'b0);
        check(n_res, r0);
        wact = 1'b0;
        wait_ready(RW + 10, n);
        check(n + 100 >= RW && n <= RW, 1'b1);
        u_host.ptab_read(24'h000000, 34);
        for (int i = 0; i < 34; i++) begin
            check(u_host.rd[i], (i < 32) ? hdr[i] : 8'hFF);
        end
        check(sio_oe, 4'h0);
        u_host.ptab_read(24'h000005, 2);
        check({u_host.rd[0], u_host.rd[1]}, 16'h0102);
        check(sio_oe, 4'h0);
        // Quad table read drives all four lines, a nibble per serial clock
        quad = 1'b1;
        u_host.ptab_read(24'h000010, 2);
        check({u_host.rd[0], u_host.rd[1]}, {MID, 8'h00});
        check(sio_oe, 4'h0);
        quad = 1'b0;
        test_done();
    end
endmodule : frsc_top_tb_top
